/* File: rtl/dcb_option_unit.sv */
// Command block option interpreter with chain sequencing
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "dcb_regs.svh"

module dcb_option_unit #(
    parameter int DELAY_CYC = `DCB_DELAY_CYC
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [5:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Block fetch from memory
    output logic                      fetch_req_o,
    output logic      [31:0]          fetch_addr_o,
    input  wire logic                 blk_valid_i,
    input  wire logic [31:0]          blk_next_i,
    input  wire dcb_pkg::dcb_cmd_type blk_cmd_i,
    input  wire logic [7:0]           blk_opt_i,
    input  wire logic [7:0]           blk_mark_i,
    input  wire logic [31:0]          blk_ptr_i,
    // Core events
    input  wire logic                 exec_done_i,
    input  wire logic                 result_i,
    input  wire logic                 result_fatal_i,
    input  wire logic                 last_write_i,
    input  wire logic                 buf_done_i,
    // Core controls
    output logic                      exec_o,
    output logic                      lookahead_ok_o,
    output logic                      seek_hold_o,
    output logic                      map_ptr_o,
    output logic      [31:0]          data_ptr_o,
    output logic      [7:0]           mark_o,
    output logic                      position_check_o,
    output logic                      relocate_check_o,
    output logic                      long_transfer_o,
    output logic      [2:0]           park_steps_o,
    output logic                      buffer_sel_o,
    output logic                      wait_stop_o
);
    import dcb_pkg::*;

    //--------------------------------------------------
    // Command decode
    //--------------------------------------------------
    function automatic logic [7:0] opt_mask(input dcb_cmd_type c);
        case (c)
            DCB_READ:      opt_mask = 8'hef;
            DCB_WRITE:     opt_mask = 8'hff;
            DCB_VERIFY:    opt_mask = 8'hed;
            DCB_FORMAT:    opt_mask = 8'he8;
            DCB_READ_PHYS: opt_mask = 8'hec;
            DCB_READ_ID:   opt_mask = 8'he8;
            DCB_LOAD_BUF:  opt_mask = 8'hed;
            DCB_DUMP_BUF:  opt_mask = 8'he9;
            DCB_CORRECT:   opt_mask = 8'he8;
            DCB_SEEK:      opt_mask = 8'he8;
            DCB_RESTORE:   opt_mask = 8'he9;
            DCB_CHANNEL:   opt_mask = 8'he3;
            default:       opt_mask = 8'he0;
        endcase
    endfunction

    function automatic logic is_io(input dcb_cmd_type c);
        is_io = (c == DCB_READ) || (c == DCB_WRITE) || (c == DCB_VERIFY);
    endfunction

    //--------------------------------------------------
    // State
    //--------------------------------------------------
    dcb_state_type state;
    dcb_state_type next_state;
    dcb_cmd_type   cmd;
    logic [7:0]    opt;
    logic [7:0]    mark_field;
    logic [31:0]   next_ptr;
    logic [31:0]   start_ptr;
    logic [7:0]    ctrl;
    logic          resumable;
    logic          wait_stop;
    logic          fatal_stop;
    logic          result_stop;
    logic          delay_due;
    logic          buf_sel;
    logic [31:0]   delay_cnt;

    //--------------------------------------------------
    // Bus decode
    //--------------------------------------------------
    wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr       = req & wb_we_i & wb_sel_i[0];
    wire wr_ctrl  = wr & (wb_adr_i == `DCB_OFF_CTRL);
    wire wr_start = req & wb_we_i & (wb_adr_i == `DCB_OFF_START);
    wire go       = wr_ctrl & wb_dat_i[`DCB_CTRL_GO];
    wire resume   = wr_ctrl & wb_dat_i[`DCB_CTRL_RESUME]
                  & (state == DCB_HALT) & resumable;
    wire floppy   = ctrl[`DCB_CTRL_FLOPPY];
    wire [31:0] status = {24'h0, buf_sel, result_stop, fatal_stop,
                          wait_stop, resumable, state};

    //--------------------------------------------------
    // Halt decisions
    //--------------------------------------------------
    wire stop_fatal  = result_i & result_fatal_i & opt[`DCB_OPT_FATAL];
    wire stop_result = result_i & opt[`DCB_OPT_RESULT];
    wire stop_now    = stop_fatal | stop_result;
    wire stop_wait   = exec_done_i & opt[`DCB_OPT_WAIT];
    wire delay_pend  = delay_due | (last_write_i & opt[`DCB_OPT_DELAY]);

    always_comb begin
        next_state = state;
        case (state)
            DCB_IDLE:  if (go) next_state = DCB_FETCH;
            DCB_FETCH: if (blk_valid_i) next_state = DCB_EXEC;
            DCB_EXEC: begin
                if (stop_now || stop_wait)
                    next_state = DCB_HALT;
                else if (exec_done_i)
                    next_state = delay_pend ? DCB_DELAY : DCB_FETCH;
            end
            DCB_DELAY: if (delay_cnt == 32'h0) next_state = DCB_FETCH;
            DCB_HALT:  if (go || resume) next_state = DCB_FETCH;
            default:   next_state = DCB_IDLE;
        endcase
    end

    //--------------------------------------------------
    // Sequencer registers
    //--------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state      <= DCB_IDLE;
            cmd        <= DCB_LOAD_PARAM;
            opt        <= 8'h00;
            mark_field <= 8'h00;
            next_ptr   <= 32'h0;
            data_ptr_o <= 32'h0;
            resumable  <= 1'b0;
        end else begin
            state <= next_state;
            if (state == DCB_FETCH && blk_valid_i) begin
                cmd        <= blk_cmd_i;
                opt        <= blk_opt_i & opt_mask(blk_cmd_i);
                mark_field <= blk_mark_i;
                next_ptr   <= blk_next_i;
                data_ptr_o <= blk_ptr_i;
            end
            if (state == DCB_EXEC) begin
                if (stop_now)
                    resumable <= ~result_fatal_i;
                else if (stop_wait)
                    resumable <= 1'b1;
            end else if (go || resume) begin
                resumable <= 1'b0;
            end
        end
    end

    // Fetch address: start pointer on go, else chain pointer
    always_ff @(posedge clk_i) begin
        if (rst_i)
            fetch_addr_o <= 32'h0;
        else if (go)
            fetch_addr_o <= start_ptr;
        else if ((state == DCB_EXEC && exec_done_i) || resume)
            fetch_addr_o <= next_ptr;
    end

    // Sticky stop flags, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_stop   <= 1'b0;
            fatal_stop  <= 1'b0;
            result_stop <= 1'b0;
        end else if (state == DCB_EXEC) begin
            wait_stop   <= wait_stop | (stop_wait & ~stop_now);
            fatal_stop  <= fatal_stop | (stop_now & result_fatal_i);
            result_stop <= result_stop | stop_result;
        end else if (go || resume) begin
            wait_stop   <= 1'b0;
            fatal_stop  <= 1'b0;
            result_stop <= 1'b0;
        end
    end

    // Post-write delay before the next fetch when the chain continues; lookahead_ok_o not held off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            delay_due <= 1'b0;
            delay_cnt <= 32'h0;
        end else begin
            if (state == DCB_FETCH)
                delay_due <= 1'b0;
            else if (state == DCB_EXEC && last_write_i
                     && opt[`DCB_OPT_DELAY])
                delay_due <= 1'b1;
            if (state == DCB_EXEC)
                delay_cnt <= 32'(DELAY_CYC - 1);
            else if (state == DCB_DELAY && delay_cnt != 32'h0)
                delay_cnt <= delay_cnt - 32'h1;
        end
    end

    // Sector buffer select
    always_ff @(posedge clk_i) begin
        if (rst_i)
            buf_sel <= 1'b0;
        else if (state == DCB_EXEC && buf_done_i && opt[`DCB_OPT_B0]
                 && (cmd == DCB_LOAD_BUF || cmd == DCB_DUMP_BUF))
            buf_sel <= ~buf_sel;
    end

    //--------------------------------------------------
    // Wishbone registers
    //--------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl      <= `DCB_CTRL_RESET;
            start_ptr <= 32'h0;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h0;
        end else begin
            wb_ack_o <= req;
            if (wr_ctrl)
                ctrl <= {4'h0, wb_dat_i[3:2], 2'b00};
            if (wr_start)
                start_ptr <= wb_dat_i;
            if (req) begin
                case (wb_adr_i)
                    `DCB_OFF_CTRL:  wb_dat_o <= {24'h0, ctrl};
                    `DCB_OFF_STAT:  wb_dat_o <= status;
                    `DCB_OFF_START: wb_dat_o <= start_ptr;
                    `DCB_OFF_NEXT:  wb_dat_o <= next_ptr;
                    `DCB_OFF_OPT:   wb_dat_o <= {16'h0, cmd, opt};
                    default:        wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    //--------------------------------------------------
    // Control outputs
    //--------------------------------------------------
    wire custom_mark = opt[`DCB_OPT_MARK]
                     & (is_io(cmd) | (cmd == DCB_READ_PHYS));
    wire pos_opt     = opt[`DCB_OPT_B3] & ((cmd == DCB_SEEK)
                     | (cmd == DCB_RESTORE) | (cmd == DCB_READ_PHYS));

    assign fetch_req_o      = (state == DCB_FETCH);
    assign exec_o           = (state == DCB_EXEC);
    assign lookahead_ok_o   = exec_o & ~opt[`DCB_OPT_WAIT];
    assign seek_hold_o      = (state == DCB_DELAY);
    assign map_ptr_o        = opt[`DCB_OPT_B3] & (is_io(cmd)
                            | (cmd == DCB_FORMAT) | (cmd == DCB_LOAD_BUF)
                            | (cmd == DCB_DUMP_BUF));
    assign mark_o           = custom_mark ? mark_field
                            : floppy ? `DCB_MARK_FLOPPY
                            : `DCB_MARK_HARD;
    assign position_check_o = is_io(cmd) | pos_opt;
    assign relocate_check_o = is_io(cmd) & ~opt[`DCB_OPT_B0]
                            & ctrl[`DCB_CTRL_AUTOREL];
    assign long_transfer_o  = opt[`DCB_OPT_LONG]
                            & (cmd == DCB_READ || cmd == DCB_WRITE);
    assign park_steps_o     = (cmd == DCB_RESTORE && opt[`DCB_OPT_B0])
                            ? `DCB_PARK_STEPS : 3'd0;
    assign buffer_sel_o     = buf_sel;
    assign wait_stop_o      = wait_stop;

    //--------------------------------------------------
    // Check helpers
    //--------------------------------------------------
    // Counts cycles of the post-write hold for the length check
    logic [31:0] hold_cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i || !seek_hold_o)
            hold_cnt <= 32'h0;
        else
            hold_cnt <= hold_cnt + 32'h1;
    end

    //--------------------------------------------------
    // Assertions
    //--------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_wait_halts: assert property (exec_o && stop_wait && !stop_now |=>
        state == DCB_HALT && wait_stop && resumable)
        else $error("wait option did not halt resumably");
    a_chain_continues: assert property (exec_o && exec_done_i
        && !stop_now && !stop_wait && !delay_pend |=> fetch_req_o
        && fetch_addr_o == $past(next_ptr))
        else $error("chain did not continue to next block");
    a_fatal_stop: assert property (exec_o && stop_fatal |=>
        state == DCB_HALT && !resumable)
        else $error("fatal stop not final");
    a_result_stop: assert property (exec_o && stop_result
        |=> state == DCB_HALT)
        else $error("result block did not halt chain");
    a_result_resume: assert property (exec_o && stop_result
        && !result_fatal_i |=> resumable)
        else $error("non-fatal result halt not resumable");
    a_no_lookahead: assert property (opt[`DCB_OPT_WAIT]
        |-> !lookahead_ok_o)
        else $error("look-ahead past waiting block");
    a_default_mark: assert property (!custom_mark && floppy
        |-> mark_o == 8'hfb)
        else $error("floppy default mark wrong");
    a_post_delay: assert property (exec_o && exec_done_i && !stop_now
        && !stop_wait && delay_pend |=> seek_hold_o [*8])
        else $error("post-write delay too short");
    a_io_verify: assert property (is_io(cmd) |-> position_check_o)
        else $error("data command skipped position check");
    a_park_five: assert property (cmd == DCB_RESTORE
        && opt[`DCB_OPT_B0] |-> park_steps_o == 3'd5)
        else $error("park offset not five tracks");
    a_mask_opts: assert property (fetch_req_o && blk_valid_i
        |=> (opt & ~opt_mask(cmd)) == 8'h00)
        else $error("undefined option bit kept");

    a_resume_addr: assert property (resume && !go |=> fetch_req_o
        && fetch_addr_o == $past(next_ptr) && !wait_stop_o)
        else $error("resume did not refetch chain");
    a_fatal_final: assert property (state == DCB_HALT
        && !resumable && !go |=> state == DCB_HALT)
        else $error("final halt left without go");
    a_result_final: assert property (exec_o && stop_result
        && result_fatal_i |=> !resumable)
        else $error("fatal result halt resumable");
    a_halt_mid: assert property (exec_o && stop_now
        |=> !exec_o && !fetch_req_o)
        else $error("chain ran on after result block");

    a_map_linear: assert property (!opt[`DCB_OPT_B3] |-> !map_ptr_o)
        else $error("map used with option clear");
    a_data_ptr: assert property (fetch_req_o && blk_valid_i
        |=> data_ptr_o == $past(blk_ptr_i))
        else $error("data pointer not taken from block");
    a_format_mark: assert property (cmd == DCB_FORMAT && !floppy
        |-> mark_o == 8'hf8)
        else $error("format used custom mark");
    a_custom_mark: assert property (opt[`DCB_OPT_MARK] && is_io(cmd)
        |-> mark_o == mark_field)
        else $error("custom mark not applied");

    a_buf_swap: assert property (exec_o && buf_done_i
        && opt[`DCB_OPT_B0] && cmd == DCB_LOAD_BUF
        |=> buffer_sel_o != $past(buffer_sel_o))
        else $error("buffer did not swap");
    a_reloc_skip: assert property (opt[`DCB_OPT_B0] && is_io(cmd)
        |-> !relocate_check_o)
        else $error("relocated-track check not skipped");
    a_long_only: assert property (long_transfer_o
        |-> cmd == DCB_READ || cmd == DCB_WRITE)
        else $error("long transfer on other command");
    a_delay_arm: assert property (exec_o && last_write_i
        && opt[`DCB_OPT_DELAY] |=> delay_due)
        else $error("post-write delay not armed");
    a_hold_length: assert property (seek_hold_o
        && next_state != DCB_DELAY |-> hold_cnt == 32'(DELAY_CYC - 1))
        else $error("post-write delay length wrong");

    c_wait_halt:   cover property (exec_o && stop_wait ##1 resume);
    c_fatal_halt:  cover property (exec_o && stop_fatal);
    c_delay_fetch: cover property (seek_hold_o ##1 fetch_req_o);
    c_buf_toggle:  cover property ($changed(buf_sel));
    c_result_stop: cover property (exec_o && stop_result && !result_fatal_i);

endmodule

/* File: rtl/dcb_pkg.sv */
// Types shared by the command block option interpreter
package dcb_pkg;

    typedef enum logic [7:0] {
        DCB_LOAD_PARAM = 8'h00, DCB_LOAD_BUF  = 8'h01,
        DCB_DUMP_BUF   = 8'h02, DCB_DUMP_PARAM = 8'h03,
        DCB_LOAD_SYN   = 8'h04, DCB_DUMP_SYN  = 8'h05,
        DCB_CORRECT    = 8'h06, DCB_FORMAT    = 8'h07,
        DCB_RESTORE    = 8'h08, DCB_READ_ID   = 8'h09,
        DCB_READ_PHYS  = 8'h0a, DCB_RELOCATE  = 8'h0b,
        DCB_READ       = 8'h0c, DCB_WRITE     = 8'h0d,
        DCB_SEEK       = 8'h0e, DCB_VERIFY    = 8'h0f,
        DCB_CHANNEL    = 8'h10
    } dcb_cmd_type;

    typedef enum logic [2:0] {
        DCB_IDLE  = 3'b000,
        DCB_FETCH = 3'b001,
        DCB_EXEC  = 3'b010,
        DCB_DELAY = 3'b011,
        DCB_HALT  = 3'b100
    } dcb_state_type;

endpackage

/* File: rtl/dcb_regs.svh */
// Register offsets, option bit positions, marks and timing counts
// Operation
// - Any option combination applies, each independently
// - Wait clear: continue with next block
// - Wait set: end chain, flag wait-stop fault
// - No seek look-ahead past waiting block
// - Wait halt stays resumable
// - Stop-on-fatal: fatal error halts, not resumable
// - Stop-on-result: any result block halts chain
// - Result halt resumable only for non-fatal
// - Halt right after result block write
// - Map off: pointer addresses linear data
// - Map on: pointer addresses first map entry
// - Default mark F8 hard, FB floppy
// - Format uses default mark, marks never ignored
// - Custom mark from field, data commands only; code also applies it to read physical
// - Position check: mispositioned gives seek error only
// - Read, write, verify always check position
// - Buffer swap after buffer loaded or dumped
// - Relocate enabled plus auto bit: handle relocation
// - Relocate disabled: skip relocated-track check
// - Post-write delay 1 ms before seek; code holds only a continuing chain's fetch, not look-ahead
// - Restore with park: step in five first
// - Long option selects long read/write
`ifndef DCB_REGS_SVH
`define DCB_REGS_SVH

`define DCB_OFF_CTRL   6'h00
`define DCB_OFF_STAT   6'h04
`define DCB_OFF_START  6'h08
`define DCB_OFF_NEXT   6'h0c
`define DCB_OFF_OPT    6'h10

`define DCB_CTRL_GO      0
`define DCB_CTRL_RESUME  1
`define DCB_CTRL_FLOPPY  2
`define DCB_CTRL_AUTOREL 3
`define DCB_CTRL_RESET   8'h00

`define DCB_OPT_WAIT   7
`define DCB_OPT_FATAL  6
`define DCB_OPT_RESULT 5
`define DCB_OPT_DELAY  4
`define DCB_OPT_B3     3
`define DCB_OPT_MARK   2
`define DCB_OPT_LONG   1
`define DCB_OPT_B0     0

`define DCB_MARK_HARD   8'hf8
`define DCB_MARK_FLOPPY 8'hfb
`define DCB_PARK_STEPS  3'd5

`define DCB_DELAY_US    1000
`define DCB_CLK_MHZ     40
`define DCB_DELAY_CYC   (`DCB_DELAY_US * `DCB_CLK_MHZ)

`endif

/* File: tb/dcb_mem_model.sv */
// Memory-side model that serves command blocks on fetch requests
`timescale 1ns/10ps

module dcb_mem_model (
    // Clock and fetch request
    input  wire logic            clk_i,
    input  wire logic            fetch_req_i,
    input  wire logic [31:0]     fetch_addr_i,
    input  wire logic [3:0]      lat_i,
    // Block fields
    output logic                 blk_valid_o,
    output logic      [31:0]     blk_next_o,
    output dcb_pkg::dcb_cmd_type blk_cmd_o,
    output logic      [7:0]      blk_opt_o,
    output logic      [7:0]      blk_mark_o,
    output logic      [31:0]     blk_ptr_o
);
    import dcb_pkg::*;
    //------------------------------------------------------------
    // Block table, one block every 16 bytes
    //------------------------------------------------------------
    logic [7:0] cmd [9] = '{8'h0c, 8'h0c, 8'h0d, 8'h0c, 8'h0c, 8'h0c,
                            8'h07, 8'h01, 8'h08};
    logic [7:0] opt [9] = '{8'h00, 8'h80, 8'h10, 8'h40, 8'h20, 8'h0f,
                            8'h04, 8'h01, 8'h81};
    logic [3:0] cnt;
    logic [3:0] ix;
    logic [31:0] nxt;
    logic [31:0] ptr;
    assign ix  = fetch_addr_i[7:4];
    assign nxt = fetch_addr_i + 32'h10;
    assign ptr = {24'h00c0de, fetch_addr_i[7:0]};
    // Fields outside the strobe show inverted values, never stale ones
    assign blk_next_o = blk_valid_o ? nxt : ~nxt;
    assign blk_cmd_o  = dcb_cmd_type'(blk_valid_o ? cmd[ix] : ~cmd[ix]);
    assign blk_opt_o  = blk_valid_o ? opt[ix] : ~opt[ix];
    assign blk_mark_o = blk_valid_o ? 8'h5a : 8'ha5;
    assign blk_ptr_o  = blk_valid_o ? ptr : ~ptr;
    initial begin
        blk_valid_o = 1'b0;
        cnt = 4'h0;
    end
    always @(posedge clk_i) begin
        if (blk_valid_o) begin
            blk_valid_o <= 1'b0;
            cnt <= 4'h0;
        end else if (fetch_req_i && cnt >= lat_i) begin
            blk_valid_o <= 1'b1;
        end else if (fetch_req_i) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

/* File: tb/dcb_option_unit_tb_top.sv */
// Self-checking bench for the command block option interpreter
`timescale 1ns/10ps
`include "dcb_regs.svh"

module dcb_option_unit_tb_top;
    import dcb_pkg::*;
    localparam int DLY = 20;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i, lat;
    logic [31:0] wb_dat_i, wb_dat_o, rd, fetch_addr_o, blk_next_i;
    logic [31:0] blk_ptr_i, data_ptr_o;
    logic [7:0] blk_opt_i, blk_mark_i, mark_o;
    logic [2:0] park_steps_o;
    dcb_cmd_type blk_cmd_i;
    logic fetch_req_o, blk_valid_i, exec_done_i, result_i, result_fatal_i;
    logic last_write_i, buf_done_i, exec_o, lookahead_ok_o, seek_hold_o;
    logic map_ptr_o, position_check_o, relocate_check_o, long_transfer_o;
    logic buffer_sel_o, wait_stop_o;
    int n_errors, cmp_count;

    dcb_option_unit #(.DELAY_CYC(DLY)) dcb_option_unit_inst (.clk_i,
        .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .fetch_req_o, .fetch_addr_o,
        .blk_valid_i, .blk_next_i, .blk_cmd_i, .blk_opt_i, .blk_mark_i,
        .blk_ptr_i, .exec_done_i, .result_i, .result_fatal_i, .last_write_i,
        .buf_done_i, .exec_o, .lookahead_ok_o, .seek_hold_o, .map_ptr_o,
        .data_ptr_o, .mark_o, .position_check_o, .relocate_check_o,
        .long_transfer_o, .park_steps_o, .buffer_sel_o, .wait_stop_o);
    dcb_mem_model dcb_mem_model_inst (.clk_i, .fetch_req_i(fetch_req_o),
        .fetch_addr_i(fetch_addr_o), .lat_i(lat), .blk_valid_o(blk_valid_i),
        .blk_next_o(blk_next_i), .blk_cmd_o(blk_cmd_i),
        .blk_opt_o(blk_opt_i), .blk_mark_o(blk_mark_i),
        .blk_ptr_o(blk_ptr_i));

    //------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------
    task test_done;
        $display("compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task fail(input string m);
        n_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) fail(m);
    endtask
    task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (i = 0; i < 16 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
        if (i == 16) begin
            fail("bus timeout");
            test_done;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(negedge clk_i);
    endtask
    // Event order: last_write, buf_done, fatal, result, exec_done
    task pulse(input logic [4:0] m);
        @(posedge clk_i);
        {last_write_i, buf_done_i, result_fatal_i, result_i, exec_done_i} <= m;
        @(posedge clk_i);
        {last_write_i, buf_done_i, result_fatal_i, result_i, exec_done_i}
            <= 5'h00;
        @(negedge clk_i);
    endtask
    task wait_exec;
        int i;
        for (i = 0; i < 40 && exec_o !== 1'b1; i++) @(posedge clk_i);
        if (i == 40) begin
            fail("block never executed");
            test_done;
        end
        @(negedge clk_i);
    endtask

    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    task t_reset;
        @(negedge clk_i);
        chk(mark_o, 8'hf8, "reset mark");
        chk({exec_o, fetch_req_o, wait_stop_o}, 3'h0, "reset outputs");
        wb(1'b0, 6'h3c, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        $display("reset test done");
    endtask
    task t_wait_chain;
        wb(1'b1, `DCB_OFF_START, 32'h0);
        wb(1'b1, `DCB_OFF_CTRL, 32'h9);
        wait_exec;
        chk(relocate_check_o, 1'b1, "auto relocate");
        chk(lookahead_ok_o, 1'b1, "lookahead");
        chk(data_ptr_o, 32'h00c0de00, "linear ptr");
        chk(map_ptr_o, 1'b0, "map off");
        lat = 4'h5;
        pulse(5'h01);
        chk(fetch_addr_o, 32'h10, "next block");
        wait_exec;
        chk(lookahead_ok_o, 1'b0, "no lookahead");
        pulse(5'h01);
        chk(wait_stop_o, 1'b1, "wait stop");
        wb(1'b0, `DCB_OFF_STAT, 32'h0);
        chk(rd[7:0], 8'h1c, "wait halt status");
        wb(1'b1, `DCB_OFF_CTRL, 32'ha);
        chk(fetch_addr_o, 32'h20, "resume addr");
        $display("wait chain test done");
    endtask
    task t_delay;
        int i, n;
        lat = 4'h0;
        n = 0;
        wait_exec;
        pulse(5'h10);
        pulse(5'h01);
        for (i = 0; i < 100 && fetch_req_o !== 1'b1; i++) begin
            if (seek_hold_o === 1'b1) n++;
            @(negedge clk_i);
        end
        chk(n, DLY, "post write delay");
        chk(fetch_addr_o, 32'h30, "addr after delay");
        $display("delay test done");
    endtask
    task t_fatal;
        wait_exec;
        pulse(5'h02);
        chk(exec_o, 1'b1, "non-fatal kept running");
        pulse(5'h06);
        wb(1'b0, `DCB_OFF_STAT, 32'h0);
        chk(rd[7:0], 8'h24, "fatal halt status");
        wb(1'b1, `DCB_OFF_CTRL, 32'ha);
        chk(fetch_req_o, 1'b0, "fatal not resumable");
        $display("fatal test done");
    endtask
    task t_result;
        wb(1'b1, `DCB_OFF_START, 32'h40);
        wb(1'b1, `DCB_OFF_CTRL, 32'h9);
        wait_exec;
        pulse(5'h02);
        chk(exec_o, 1'b0, "halt mid block");
        wb(1'b0, `DCB_OFF_STAT, 32'h0);
        chk(rd[7:0], 8'h4c, "result halt status");
        wb(1'b1, `DCB_OFF_CTRL, 32'he);
        chk(fetch_addr_o, 32'h50, "result resume");
        $display("result test done");
    endtask
    task t_options;
        wait_exec;
        chk(mark_o, 8'h5a, "custom mark");
        chk(long_transfer_o, 1'b1, "long transfer");
        chk(map_ptr_o, 1'b1, "map on");
        chk(data_ptr_o, 32'h00c0de50, "map ptr");
        chk(relocate_check_o, 1'b0, "relocate off");
        chk(position_check_o, 1'b1, "implied check");
        pulse(5'h01);
        wait_exec;
        chk(mark_o, 8'hfb, "format mark");
        chk(long_transfer_o, 1'b0, "masked option");
        wb(1'b0, `DCB_OFF_OPT, 32'h0);
        chk(rd, 32'h0700, "format option mask");
        pulse(5'h01);
        wait_exec;
        pulse(5'h08);
        chk(buffer_sel_o, 1'b1, "buffer swap");
        pulse(5'h01);
        wait_exec;
        chk(park_steps_o, 3'h5, "park steps");
        chk(position_check_o, 1'b0, "no position check");
        pulse(5'h01);
        chk(wait_stop_o, 1'b1, "combined options");
        $display("options test done");
    endtask

    //------------------------------------------------------------
    // Clock, reset and sequence
    //------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        n_errors = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        lat = 4'h0;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 6'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        {last_write_i, buf_done_i, result_fatal_i, result_i, exec_done_i}
            = 5'h00;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_wait_chain;
        t_delay;
        t_fatal;
        t_result;
        t_options;
        test_done;
    end
endmodule
